/* File: core/watchdog_pkg.sv */
package watchdog_pkg;
	// ==========================================
	// Register addresses (byte addresses of the peripheral space)
	localparam logic [31:0] TCS_ADDR = 32'hFFFF8610;
	localparam logic [31:0] CNT_RD_ADDR = 32'hFFFF8611;
	localparam logic [31:0] RCS_WR_ADDR = 32'hFFFF8612;
	localparam logic [31:0] RCS_RD_ADDR = 32'hFFFF8613;
	// ==========================================
	// Word-write key bytes in the upper half of the written word
	localparam logic [7:0] KEY_TCS_CNT = 8'hA5;
	localparam logic [7:0] KEY_CNT = 8'h5A;
	localparam logic [7:0] KEY_RCS_FLAG = 8'hA5;
	localparam logic [7:0] KEY_RCS_CTRL = 8'h5A;
	// ==========================================
	// Field positions
	localparam int FLAG_BIT = 7;
	localparam int MODE_BIT = 6;
	localparam int ENABLE_BIT = 5;
	localparam int RSTE_BIT = 6;
	// ==========================================
	// Reset values
	localparam logic [7:0] TCS_RESET = 8'h18;
	localparam logic [7:0] CNT_RESET = 8'h00;
	localparam logic [7:0] RCS_RESET = 8'h1F;
	localparam logic [1:0] TCS_FIXED_ONES = 2'h3;
	localparam logic [4:0] RCS_FIXED_ONES = 5'h1F;
	// ==========================================
	// Bus access sizes
	typedef enum logic [1:0] {
		SIZE_BYTE = 2'b00,
		SIZE_WORD = 2'b01,
		SIZE_LONG = 2'b10
	} access_size_t;
	// ==========================================
	// Prescaler: 13 bits covers the largest divide of 8192
	localparam int PRESCALE_WIDTH = 13;
	// Overflow pulse width in system clocks for the external pin and chip reset
	localparam int PULSE_CYCLES = 128;
	localparam logic [7:0] PULSE_COUNT = 8'(PULSE_CYCLES - 1);
endpackage : watchdog_pkg

/* File: core/clock_tap_select.sv */
// Picks one of eight prescaler taps and emits a one-cycle count strobe on its rising edge
module clock_tap_select
	import watchdog_pkg::*;
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	// Control
	input wire logic i_run,
	input wire logic [2:0] i_select,
	// Strobe
	output logic o_tick
);
	logic [PRESCALE_WIDTH-1:0] prescale;
	logic tap;
	logic tap_prev;

	// Divides 2,64,128,256,512,1024,4096,8192 use bits 0,5,6,7,8,9,11,12
	always_comb begin
		case (i_select)
			3'h0: tap = prescale[0];
			3'h1: tap = prescale[5];
			3'h2: tap = prescale[6];
			3'h3: tap = prescale[7];
			3'h4: tap = prescale[8];
			3'h5: tap = prescale[9];
			3'h6: tap = prescale[11];
			3'h7: tap = prescale[12];
			default: tap = 1'b0;
		endcase
	end

	// Prescaler held clear while stopped so the first strobe comes after half an interval
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prescale <= '0;
			tap_prev <= 1'b0;
			o_tick <= 1'b0;
		end else if (i_clk_en) begin
			if (!i_run) begin
				prescale <= '0;
				tap_prev <= 1'b0;
				o_tick <= 1'b0;
			end else begin
				prescale <= prescale + PRESCALE_WIDTH'(1);
				tap_prev <= tap;
				o_tick <= tap & ~tap_prev;
			end
		end
	end
endmodule : clock_tap_select

/* File: core/watchdog_interval_timer.sv */
// Operation
// - Watchdog overflow drives active-low overflow pin
// - Optional chip reset with watchdog overflow
// - Interval mode overflow raises timer interrupt
// - Overflow strobe pulses the wake output; standby clears the enable, so no overflow occurs in standby
// - Eight selectable internal count clock sources
// - One channel shared by both modes
// - Writes accepted only as word transfers
// - Reads served only as byte transfers
// - Flag bit seven clears only on a written zero after a read, or in standby
// - Reset status written and read at different addresses
// - Eight-bit up-counter overflows from FF to 00
module watchdog_interval_timer
	import watchdog_pkg::*;
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	// Register access port
	input wire logic i_req,
	input wire logic i_write,
	input wire logic [31:0] i_addr,
	input wire logic [1:0] i_size,
	input wire logic [15:0] i_wdata,
	output logic [7:0] o_rdata,
	output logic o_ack,
	// Standby control
	input wire logic i_standby,
	// Events
	output logic o_overflow_out_n,
	output logic o_chip_reset,
	output logic o_interval_irq,
	output logic o_standby_wake
);
	logic [7:0] timer_count;
	logic ovf_flag;
	logic mode_watchdog;
	logic timer_enable;
	logic [2:0] clock_select;
	logic wovf_flag;
	logic reset_enable;
	logic tick;
	logic overflow;
	logic [7:0] pulse_count;
	logic pulse_active;
	logic ovf_read;
	logic wovf_read;
	logic wr_word;
	logic rd_byte;
	logic [7:0] wkey;
	logic [7:0] wbyte;

	// ==========================================
	// Bus decode
	// word writes
	assign wr_word = i_req & i_write & (i_size == SIZE_WORD);
	assign rd_byte = i_req & ~i_write & (i_size == SIZE_BYTE);
	assign wkey = i_wdata[15:8];
	assign wbyte = i_wdata[7:0];

	// ==========================================
	// Count clock
	// eight sources
	clock_tap_select u_tap (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_clk_en(i_clk_en),
		.i_run(timer_enable),
		.i_select(clock_select),
		.o_tick(tick)
	);

	assign overflow = tick & timer_enable & (timer_count == 8'hFF);

	// ==========================================
	// Counter
	// single channel
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			timer_count <= CNT_RESET;
		end else if (i_clk_en) begin
			if (!timer_enable) begin
				timer_count <= CNT_RESET;
			end else if (wr_word && i_addr == TCS_ADDR && wkey == KEY_CNT) begin
				timer_count <= wbyte;
			end else if (tick) begin
				timer_count <= timer_count + 8'h01;
			end
		end
	end

	// ==========================================
	// Control and status
	// Standby clears mode, enable and flag; the clock select survives
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ovf_flag <= TCS_RESET[FLAG_BIT];
			mode_watchdog <= TCS_RESET[MODE_BIT];
			timer_enable <= TCS_RESET[ENABLE_BIT];
			clock_select <= TCS_RESET[2:0];
		end else if (i_clk_en) begin
			if (i_standby) begin
				ovf_flag <= 1'b0;
				mode_watchdog <= 1'b0;
				timer_enable <= 1'b0;
			end else begin
				if (wr_word && i_addr == TCS_ADDR && wkey == KEY_TCS_CNT) begin
					mode_watchdog <= wbyte[MODE_BIT];
					timer_enable <= wbyte[ENABLE_BIT];
					clock_select <= wbyte[2:0];
				end
				// interval flag; set wins over clear
				if (overflow && !mode_watchdog) begin
					ovf_flag <= 1'b1;
				// clear only on written zero after a read
				end else if (wr_word && i_addr == TCS_ADDR && wkey == KEY_TCS_CNT && !wbyte[FLAG_BIT] && ovf_read) begin
					ovf_flag <= 1'b0;
				end
			end
		end
	end

	// Reset control register survives the self-generated chip reset
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wovf_flag <= RCS_RESET[FLAG_BIT];
			reset_enable <= RCS_RESET[RSTE_BIT];
		end else if (i_clk_en) begin
			if (i_standby) begin
				wovf_flag <= 1'b0;
				reset_enable <= 1'b0;
			end else begin
				if (wr_word && i_addr == RCS_WR_ADDR && wkey == KEY_RCS_CTRL) begin
					reset_enable <= wbyte[RSTE_BIT];
				end
				if (overflow && mode_watchdog) begin
					wovf_flag <= 1'b1;
				end else if (wr_word && i_addr == RCS_WR_ADDR && wkey == KEY_RCS_FLAG && !wbyte[FLAG_BIT] && wovf_read) begin
					wovf_flag <= 1'b0;
				end
			end
		end
	end

	// Flags must be seen set by a read before a clear is honoured
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ovf_read <= 1'b0;
			wovf_read <= 1'b0;
		end else if (i_clk_en) begin
			if (!ovf_flag) begin
				ovf_read <= 1'b0;
			end else if (rd_byte && i_addr == TCS_ADDR) begin
				ovf_read <= 1'b1;
			end
			if (!wovf_flag) begin
				wovf_read <= 1'b0;
			end else if (rd_byte && i_addr == RCS_RD_ADDR) begin
				wovf_read <= 1'b1;
			end
		end
	end

	// ==========================================
	// Watchdog overflow pulse
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pulse_count <= 8'h00;
			pulse_active <= 1'b0;
			o_overflow_out_n <= 1'b1;
			o_chip_reset <= 1'b0;
		end else if (i_clk_en) begin
			if (overflow && mode_watchdog) begin
				pulse_active <= 1'b1;
				pulse_count <= PULSE_COUNT;
				o_overflow_out_n <= 1'b0;
				o_chip_reset <= reset_enable;
			end else if (pulse_active) begin
				if (pulse_count == 8'h00) begin
					pulse_active <= 1'b0;
					o_overflow_out_n <= 1'b1;
					o_chip_reset <= 1'b0;
				end else begin
					pulse_count <= pulse_count - 8'h01;
				end
			end
		end
	end

	// ==========================================
	// Interrupt and standby wake
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_interval_irq <= 1'b0;
			o_standby_wake <= 1'b0;
		end else if (i_clk_en) begin
			o_interval_irq <= ovf_flag | (overflow & ~mode_watchdog);
			o_standby_wake <= overflow;
		end
	end

	// ==========================================
	// Read data, one cycle after the request
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= 8'h00;
			o_ack <= 1'b0;
		end else if (i_clk_en) begin
			o_ack <= i_req;
			o_rdata <= 8'h00;
			if (rd_byte) begin
				case (i_addr)
					TCS_ADDR: o_rdata <= {ovf_flag, mode_watchdog, timer_enable, TCS_FIXED_ONES, clock_select};
					CNT_RD_ADDR: o_rdata <= timer_count;
					RCS_RD_ADDR: o_rdata <= {wovf_flag, reset_enable, 1'b0, RCS_FIXED_ONES};
					default: o_rdata <= 8'h00;
				endcase
			end
		end
	end
endmodule : watchdog_interval_timer

/* File: bench/ovf_supervisor.sv */
module ovf_supervisor (
	// Watched pin
	input wire logic i_clock,
	input wire logic i_overflow_out_n,
	// Clocks in the last low pulse
	output int o_last_len
);
	timeunit 1ns;
	timeprecision 100ps;
	int run = 0;
	// ==========
	// Pulse meter; a supervisor sees only the pin, never the registers
	always @(posedge i_clock) begin
		if (!i_overflow_out_n)
			run <= run + 1;
		else if (run != 0) begin
			o_last_len <= run;
			run <= 0;
		end
	end
endmodule : ovf_supervisor

/* File: bench/wdt_checker_assertions.sv */
module wdt_checker
	import watchdog_pkg::*;
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	// Requests
	input wire logic i_req,
	input wire logic i_write,
	input wire logic [31:0] i_addr,
	input wire logic [1:0] i_size,
	input wire logic i_standby,
	// Answers and events
	input wire logic [7:0] o_rdata,
	input wire logic o_ack,
	input wire logic o_overflow_out_n,
	input wire logic o_chip_reset,
	input wire logic o_interval_irq,
	input wire logic o_standby_wake
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	logic [8:0] low_cnt;
	logic rd;
	logic clr;
	assign rd = i_req && i_clk_en && !i_write && i_size == 2'h0;
	assign clr = i_req && i_write || i_standby;
	// ==========
	// Low time of the pin, frozen with the block
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n)
			low_cnt <= 9'h000;
		else if (o_overflow_out_n)
			low_cnt <= 9'h000;
		else if (i_clk_en)
			low_cnt <= low_cnt + 9'h001;
	end
	a_ack_next: assert property (i_req && i_clk_en |=> o_ack)
		else $error("no ack");
	a_rdata_idle: assert property (!o_ack |-> o_rdata == 8'h00)
		else $error("rdata without ack");
	a_ctrl_fixed: assert property (rd && i_addr == TCS_ADDR |=> o_rdata[4:3] == 2'h3)
		else $error("control fixed bits");
	a_pin_width: assert property ($rose(o_overflow_out_n) |-> low_cnt == 9'(PULSE_CYCLES))
		else $error("pin pulse width");
	a_reset_pin: assert property (o_chip_reset |-> !o_overflow_out_n)
		else $error("chip reset outside pulse");
	a_wake_pulse: assert property (o_standby_wake |=> !o_standby_wake)
		else $error("wake too long");
	a_irq_hold: assert property ($fell(o_interval_irq) |-> $past(clr) || $past(clr, 2))
		else $error("irq dropped by itself");
	a_irq_no_pin: assert property ($rose(o_interval_irq) |-> o_overflow_out_n)
		else $error("pin low in interval mode");
endmodule : wdt_checker

bind watchdog_interval_timer wdt_checker chk (
	.i_clock(i_clock),
	.i_rst_n(i_rst_n),
	.i_clk_en(i_clk_en),
	.i_req(i_req),
	.i_write(i_write),
	.i_addr(i_addr),
	.i_size(i_size),
	.i_standby(i_standby),
	.o_rdata(o_rdata),
	.o_ack(o_ack),
	.o_overflow_out_n(o_overflow_out_n),
	.o_chip_reset(o_chip_reset),
	.o_interval_irq(o_interval_irq),
	.o_standby_wake(o_standby_wake)
);

/* File: bench/watchdog_interval_timer_tb.sv */
module watchdog_interval_timer_tb
	import watchdog_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_clock = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_clk_en = 1'b1;
	logic i_req = 1'b0;
	logic i_write = 1'b0;
	logic [31:0] i_addr = 32'h00000000;
	logic [1:0] i_size = 2'h0;
	logic [15:0] i_wdata = 16'h0000;
	logic i_standby = 1'b0;
	logic [7:0] o_rdata;
	logic o_ack, o_overflow_out_n, o_chip_reset, o_interval_irq, o_standby_wake;
	logic [7:0] rd;
	int err_total = 0;
	int n_checks = 0;
	int wakes = 0;
	int plen;
	watchdog_interval_timer dut (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_clk_en(i_clk_en),
		.i_req(i_req),
		.i_write(i_write),
		.i_addr(i_addr),
		.i_size(i_size),
		.i_wdata(i_wdata),
		.o_rdata(o_rdata),
		.o_ack(o_ack),
		.i_standby(i_standby),
		.o_overflow_out_n(o_overflow_out_n),
		.o_chip_reset(o_chip_reset),
		.o_interval_irq(o_interval_irq),
		.o_standby_wake(o_standby_wake)
	);
	ovf_supervisor sup (.i_clock(i_clock), .i_overflow_out_n(o_overflow_out_n), .o_last_len(plen));
	initial begin
		forever #20 i_clock = ~i_clock;
	end
	always @(posedge i_clock) begin
		if (o_standby_wake === 1'b1)
			wakes++;
	end
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic conclude();
		$display("Checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude
	// One-cycle request; the answer always lands one clock later
	task automatic acc(input logic w, input logic [31:0] a, input logic [1:0] s, input logic [15:0] d);
		@(posedge i_clock);
		#1;
		i_req = 1'b1;
		i_write = w;
		i_addr = a;
		i_size = s;
		i_wdata = d;
		@(posedge i_clock);
		#1;
		i_req = 1'b0;
		rd = o_rdata;
		check("ack", 8'h01, {7'h00, o_ack});
	endtask : acc
	task automatic wr(input logic [31:0] a, input logic [7:0] key, input logic [7:0] v);
		acc(1'b1, a, 2'h1, {key, v});
	endtask : wr
	task automatic rd_chk(input logic [31:0] a, input logic [7:0] exp, input string what);
		acc(1'b0, a, 2'h0, 16'h0000);
		check(what, exp, rd);
	endtask : rd_chk
	task automatic await(ref logic sig, input logic lvl, input string what);
		for (int k = 0; k < 2000 && sig !== lvl; k++) begin
			@(posedge i_clock);
			#1;
		end
		check(what, {7'h00, lvl}, {7'h00, sig});
		if (sig !== lvl)
			conclude();
	endtask : await
	initial begin
		repeat (3) @(posedge i_clock);
		#1;
		i_rst_n = 1'b1;
		// ==========
		// Reset values and refused accesses
		rd_chk(TCS_ADDR, TCS_RESET, "control");
		rd_chk(CNT_RD_ADDR, CNT_RESET, "count");
		rd_chk(RCS_RD_ADDR, RCS_RESET, "reset control");
		rd_chk(RCS_WR_ADDR, 8'h00, "write-only address");
		acc(1'b0, TCS_ADDR, SIZE_WORD, 16'h0000);
		check("word read", 8'h00, rd);
		acc(1'b1, TCS_ADDR, SIZE_BYTE, {KEY_TCS_CNT, 8'h3F});
		acc(1'b1, TCS_ADDR, SIZE_LONG, {KEY_TCS_CNT, 8'h3F});
		rd_chk(TCS_ADDR, TCS_RESET, "sized write");
		$display("Test access done");
		// ==========
		// Interval mode on the fastest tap
		wr(TCS_ADDR, KEY_TCS_CNT, 8'hB8);
		rd_chk(TCS_ADDR, 8'h38, "flag written one");
		wr(TCS_ADDR, KEY_CNT, 8'hFE);
		await(o_interval_irq, 1'b1, "interval irq");
		check("pin idle", 8'h01, {7'h00, o_overflow_out_n});
		rd_chk(TCS_ADDR, 8'hB8, "interval flag");
		wr(TCS_ADDR, KEY_TCS_CNT, 8'h38);
		await(o_interval_irq, 1'b0, "irq clear");
		$display("Test interval done");
		// ==========
		// Watchdog mode with chip reset
		wr(TCS_ADDR, KEY_TCS_CNT, 8'h18);
		wr(RCS_WR_ADDR, KEY_RCS_CTRL, 8'h40);
		wr(TCS_ADDR, KEY_TCS_CNT, 8'h78);
		wr(TCS_ADDR, KEY_CNT, 8'hFE);
		await(o_overflow_out_n, 1'b0, "pin low");
		check("chip reset", 8'h01, {7'h00, o_chip_reset});
		wr(TCS_ADDR, KEY_TCS_CNT, 8'h18);
		rd_chk(RCS_RD_ADDR, 8'hDF, "watchdog flag");
		wr(RCS_WR_ADDR, KEY_RCS_FLAG, 8'h00);
		rd_chk(RCS_RD_ADDR, 8'h5F, "flag cleared");
		await(o_overflow_out_n, 1'b1, "pin release");
		@(posedge i_clock);
		#1;
		check("pin width", 8'(PULSE_CYCLES), plen[7:0]);
		check("wake pulses", 8'h02, wakes[7:0]);
		$display("Test watchdog done");
		// ==========
		// Clock enable freeze: twenty frozen edges must not advance the count
		wr(TCS_ADDR, KEY_TCS_CNT, 8'h38);
		i_clk_en = 1'b0;
		repeat (20) @(posedge i_clock);
		#1;
		i_clk_en = 1'b1;
		rd_chk(CNT_RD_ADDR, 8'h00, "frozen count");
		rd_chk(CNT_RD_ADDR, 8'h01, "resumed count");
		// Divide by 64: first step after half a period, next one far later
		wr(TCS_ADDR, KEY_TCS_CNT, 8'h18);
		wr(TCS_ADDR, KEY_TCS_CNT, 8'h39);
		repeat (40) @(posedge i_clock);
		rd_chk(CNT_RD_ADDR, 8'h01, "divided count");
		// Standby clears mode, enable and reset enable, keeps the clock select
		wr(RCS_WR_ADDR, KEY_RCS_CTRL, 8'h40);
		wr(TCS_ADDR, KEY_TCS_CNT, 8'h7D);
		@(posedge i_clock);
		#1;
		i_standby = 1'b1;
		repeat (2) @(posedge i_clock);
		#1;
		i_standby = 1'b0;
		rd_chk(TCS_ADDR, 8'h1D, "standby control");
		rd_chk(RCS_RD_ADDR, RCS_RESET, "standby reset control");
		rd_chk(CNT_RD_ADDR, CNT_RESET, "standby count");
		$display("Test freeze and standby done");
		conclude();
	end
endmodule : watchdog_interval_timer_tb
